// file: verilog/adcc_top.sv
// Converter control: APB registers, channel and reference routing, SAR sequencer.
// Assumes an external analog core whose comparator answers on comp_in.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter bit LOW_VOLTAGE   = 1'b0
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        comp_in,
  input  wire logic        sleep_in,
  output logic [4:0]       sh_channel_out,
  output logic             mux_connect_out,
  output logic [2:0]       ref_select_out,
  output logic             ref_valid_out,
  output logic             sample_out,
  output logic [9:0]       trial_out,
  output logic             irq_out
);
  // Channel legality per variant
  function automatic logic adcc_chan_ok(input logic [4:0] ch);
    adcc_chan_ok = !SMALL_VARIANT || (ch <= 5'h04) || ((ch >= 5'h08) && (ch <= 5'h13)) || (ch >= CH_TEMP);
  endfunction

  // Reference legality per supply range
  function automatic logic adcc_ref_ok(input logic [2:0] rs);
    adcc_ref_ok = (rs <= REF_GROUND) && !(LOW_VOLTAGE && (rs == REF_FIX4));
  endfunction

  // Mapped address check
  function automatic logic adcc_mapped(input logic [7:0] a);
    adcc_mapped = (a[1:0] == 2'h0) && (a <= OFS_IRQ_ENABLE);
  endfunction

  // Partial result: undecided bits copy the last decided bit
  function automatic logic [9:0] adcc_fill(input logic [9:0] s, input logic [3:0] k);
    logic [9:0] r;
    logic       last;
    r    = s;
    last = (k < BIT_MSB) ? s[k + 4'h1] : 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (i <= int'(k)) begin
        r[i] = last;
      end
    end
    adcc_fill = r;
  endfunction

  adcc_state_e state_reg, state_next;
  logic        en_reg, en_next, go_reg, go_next;
  logic [4:0]  chs_reg, chs_next, mux_chs_reg, mux_chs_next;
  logic [2:0]  ref_reg, ref_next, mux_ref_reg, mux_ref_next;
  logic [2:0]  cks_reg, cks_next, conv_cks_reg, conv_cks_next;
  logic        just_reg, just_next, conv_just_reg, conv_just_next;
  logic [7:0]  res_hi_reg, res_hi_next, res_lo_reg, res_lo_next;
  logic        sts_reg, sts_next, ien_reg, ien_next, irq_reg, irq_next;
  logic [4:0]  half_reg, half_next;
  logic [3:0]  bit_reg, bit_next;
  logic [9:0]  sar_reg, sar_next, sar_dec, trial_reg, trial_next, word;
  logic        done_reg, done_next, conn_reg, conn_next, refv_reg, refv_next;
  logic        sample_reg, sample_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pslverr_reg, pslverr_next;
  logic        busy, tick, wr_acc, wr_first, conv_start, abort, complete, sleep_kill;
  logic [7:0]  fmt_hi, fmt_lo;

  // Access decode
  assign wr_acc   = psel_in && penable_in && pwrite_in && pready_reg;
  assign wr_first = wr_acc && (paddr_in == OFS_CTRL_FIRST);
  assign busy     = (state_reg != ST_IDLE);
  assign sleep_kill = sleep_in && (conv_cks_reg[1:0] != CKS_FRC);
  assign conv_start = wr_first && !busy && en_reg && pwdata_in[EN_BIT] && pwdata_in[GO_BIT] &&
                      !(sleep_in && (cks_reg[1:0] != CKS_FRC));
  assign abort    = busy && ((wr_first && !(pwdata_in[GO_BIT] && pwdata_in[EN_BIT])) || sleep_kill);
  assign complete = (state_reg == ST_CONV) && tick && (half_reg == HALF_LAST);
  assign sar_dec  = sar_reg | (10'(comp_in) << bit_reg);

  adcc_clkdiv u_div (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .run_in     (busy),
    .restart_in (conv_start),
    .sel_in     (conv_cks_reg),
    .tick_out   (tick)
  );

  // Sequencer next state
  always_comb begin
    state_next    = state_reg;
    half_next     = half_reg;
    bit_next      = bit_reg;
    sar_next      = sar_reg;
    go_next       = go_reg;
    conv_cks_next = conv_cks_reg;
    conv_just_next = conv_just_reg;
    done_next     = 1'b0;
    word          = 10'h000;
    case (state_reg)
      ST_IDLE: begin
        if (conv_start) begin
          state_next     = ST_ACQ;
          half_next      = 5'h00;
          bit_next       = BIT_MSB;
          sar_next       = 10'h000;
          go_next        = 1'b1;
          conv_cks_next  = cks_reg;
          conv_just_next = just_reg;
        end
      end
      ST_ACQ: begin
        if (tick) begin
          half_next = half_reg + 5'h01;
          if (half_reg == HALF_SETUP_LAST) begin
            state_next = ST_CONV;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          half_next = half_reg + 5'h01;
          if (!half_reg[0]) begin
            sar_next = sar_dec;
            bit_next = bit_reg - 4'h1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (complete) begin
      state_next = ST_IDLE;
      go_next    = 1'b0;
      done_next  = 1'b1;
      word       = sar_dec;
    end else if (abort) begin
      state_next = ST_IDLE;
      go_next    = 1'b0;
      word       = adcc_fill(sar_reg, (state_reg == ST_CONV) ? bit_reg : BIT_MSB);
    end
    // Trial word offered to the comparator
    if (state_next == ST_CONV) begin
      trial_next = sar_next | (10'h001 << bit_next);
    end else begin
      trial_next = 10'h000;
    end
  end

  // Result formatting
  always_comb begin
    if (conv_just_next) begin
      fmt_hi = {6'h00, word[9:8]};
      fmt_lo = word[7:0];
    end else begin
      fmt_hi = word[9:2];
      fmt_lo = {word[1:0], 6'h00};
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_reg     <= ST_IDLE;
      half_reg      <= 5'h00;
      bit_reg       <= BIT_MSB;
      sar_reg       <= 10'h000;
      go_reg        <= 1'b0;
      conv_cks_reg  <= CKS_RST;
      conv_just_reg <= 1'b0;
      done_reg      <= 1'b0;
      trial_reg     <= 10'h000;
    end else begin
      state_reg     <= state_next;
      half_reg      <= half_next;
      bit_reg       <= bit_next;
      sar_reg       <= sar_next;
      go_reg        <= go_next;
      conv_cks_reg  <= conv_cks_next;
      conv_just_reg <= conv_just_next;
      done_reg      <= done_next;
      trial_reg     <= trial_next;
    end
  end

  // Register file, routing and bus answers next values
  always_comb begin
    en_next   = wr_first ? pwdata_in[EN_BIT] : en_reg;
    chs_next  = wr_first ? pwdata_in[CHS_LSB +: 5] : chs_reg;
    ref_next  = ref_reg;
    cks_next  = cks_reg;
    just_next = just_reg;
    if (wr_acc && (paddr_in == OFS_CTRL_SECOND)) begin
      ref_next  = pwdata_in[REF_LSB +: 3];
      cks_next  = pwdata_in[CKS_LSB +: 3];
      just_next = pwdata_in[JUST_BIT];
    end
    ien_next = (wr_acc && (paddr_in == OFS_IRQ_ENABLE)) ? pwdata_in[DONE_BIT] : ien_reg;
    // Hardware set wins over software clear
    if (done_next) begin
      sts_next = 1'b1;
    end else if (wr_acc && (paddr_in == OFS_IRQ_CLEAR) && pwdata_in[DONE_BIT]) begin
      sts_next = 1'b0;
    end else begin
      sts_next = sts_reg;
    end
    irq_next = sts_next && ien_next;
    res_hi_next = (done_next || abort) ? fmt_hi : res_hi_reg;
    res_lo_next = (done_next || abort) ? fmt_lo : res_lo_reg;
    // Selections follow software only while idle
    mux_chs_next = (state_next != ST_IDLE && busy) ? mux_chs_reg : chs_reg;
    mux_ref_next = (state_next != ST_IDLE && busy) ? mux_ref_reg : ref_reg;
    conn_next    = en_reg && adcc_chan_ok(mux_chs_next);
    refv_next    = adcc_ref_ok(mux_ref_next);
    sample_next  = en_reg && (state_next != ST_CONV);
    // Read data captured in the setup phase
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (psel_in && !penable_in) begin
      pslverr_next = !adcc_mapped(paddr_in);
      case (paddr_in)
        OFS_CTRL_FIRST:  prdata_next = {25'h0000000, chs_reg, go_reg, en_reg};
        OFS_CTRL_SECOND: prdata_next = {24'h000000, just_reg, cks_reg, 1'b0, ref_reg};
        OFS_RES_HIGH:    prdata_next = {24'h000000, res_hi_reg};
        OFS_RES_LOW:     prdata_next = {24'h000000, res_lo_reg};
        OFS_IRQ_STATUS:  prdata_next = {31'h00000000, sts_reg};
        OFS_IRQ_ENABLE:  prdata_next = {31'h00000000, ien_reg};
        default:         prdata_next = 32'h00000000;
      endcase
    end
  end

  // Register file registers
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      en_reg      <= 1'b0;
      chs_reg     <= CHS_RST;
      ref_reg     <= REF_RST;
      cks_reg     <= CKS_RST;
      just_reg    <= 1'b0;
      ien_reg     <= 1'b0;
      sts_reg     <= 1'b0;
      irq_reg     <= 1'b0;
      res_hi_reg  <= RES_RST;
      res_lo_reg  <= RES_RST;
      mux_chs_reg <= CHS_RST;
      mux_ref_reg <= REF_RST;
      conn_reg    <= 1'b0;
      refv_reg    <= 1'b0;
      sample_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
      pready_reg  <= 1'b0;
    end else begin
      en_reg      <= en_next;
      chs_reg     <= chs_next;
      ref_reg     <= ref_next;
      cks_reg     <= cks_next;
      just_reg    <= just_next;
      ien_reg     <= ien_next;
      sts_reg     <= sts_next;
      irq_reg     <= irq_next;
      res_hi_reg  <= res_hi_next;
      res_lo_reg  <= res_lo_next;
      mux_chs_reg <= mux_chs_next;
      mux_ref_reg <= mux_ref_next;
      conn_reg    <= conn_next;
      refv_reg    <= refv_next;
      sample_reg  <= sample_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg  <= 1'b1;
    end
  end

  // Output drive
  assign prdata_out      = prdata_reg;
  assign pready_out      = pready_reg;
  assign pslverr_out     = pslverr_reg;
  assign sh_channel_out  = mux_chs_reg;
  assign mux_connect_out = conn_reg;
  assign ref_select_out  = mux_ref_reg;
  assign ref_valid_out   = refv_reg;
  assign sample_out      = sample_reg;
  assign trial_out       = trial_reg;
  assign irq_out         = irq_reg;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_done;
    complete;
  endsequence

  property p_result_on_done;
    s_done |=> ((conv_just_reg ? {res_hi_reg[1:0], res_lo_reg} : {res_hi_reg, res_lo_reg[7:6]}) == $past(sar_dec));
  endproperty
  a_result_on_done: assert property (p_result_on_done) else $error("result not stored");

  property p_mux_follow;
    (state_reg == ST_IDLE) |=> (sh_channel_out == $past(chs_reg));
  endproperty
  a_mux_follow: assert property (p_mux_follow) else $error("channel not routed");

  property p_chan_illegal;
    !busy && !adcc_chan_ok(chs_reg) |=> !mux_connect_out;
  endproperty
  a_chan_illegal: assert property (p_chan_illegal) else $error("illegal channel connected");

  property p_irq;
    s_done ##0 ien_reg && !(wr_acc && (paddr_in == OFS_IRQ_ENABLE)) |=> irq_out && sts_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_ref_lv;
    LOW_VOLTAGE && !busy && (ref_reg == REF_FIX4) |=> !ref_valid_out;
  endproperty
  a_ref_lv: assert property (p_ref_lv) else $error("absent reference accepted");

  property p_same_write;
    wr_first && pwdata_in[EN_BIT] && pwdata_in[GO_BIT] && !en_reg |=> !go_reg && (state_reg == ST_IDLE);
  endproperty
  a_same_write: assert property (p_same_write) else $error("go taken with enable");

  property p_done_effects;
    s_done |=> !go_reg && sts_reg && done_reg;
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("completion effects wrong");

  property p_conv_len;
    conv_start && (cks_reg == 3'h0) |-> ##24 (done_reg || !go_reg);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_justify;
    done_reg |-> (conv_just_reg ? (res_hi_reg[7:2] == 6'h00) : (res_lo_reg[5:0] == 6'h00));
  endproperty
  a_justify: assert property (p_justify) else $error("justification wrong");

  property p_hold;
    busy && $past(busy) |-> $stable(ref_select_out) && $stable(sh_channel_out);
  endproperty
  a_hold: assert property (p_hold) else $error("selection moved in conversion");
endmodule

// file: verilog/adcc_pkg.sv
// Constants and types of the converter control block.
// Assumes a single system clock of 10 MHz and an APB register port.
package adcc_pkg;
  // Clock and internal RC half bit period
  localparam int CLK_PERIOD_NS   = 100;
  localparam int FRC_HALF_TAD_NS = 1000;
  localparam int FRC_HALF_CYC    = (FRC_HALF_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH    = 8'h08;
  localparam logic [7:0] OFS_RES_LOW     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h18;

  // Field positions
  localparam int EN_BIT   = 0;
  localparam int GO_BIT   = 1;
  localparam int CHS_LSB  = 2;
  localparam int REF_LSB  = 0;
  localparam int CKS_LSB  = 4;
  localparam int JUST_BIT = 7;
  localparam int DONE_BIT = 0;

  // Reset values
  localparam logic [4:0] CHS_RST   = 5'h00;
  localparam logic [2:0] REF_RST   = 3'h0;
  localparam logic [2:0] CKS_RST   = 3'h0;
  localparam logic [7:0] RES_RST   = 8'h00;

  // Conversion timing in half bit periods: 23 halves make 11.5 bit periods
  localparam logic [4:0] HALF_SETUP_LAST = 5'h02;
  localparam logic [4:0] HALF_LAST       = 5'h16;
  localparam logic [3:0] BIT_MSB         = 4'h9;

  // Internal channel codes
  localparam logic [4:0] CH_TEMP  = 5'h1C;
  localparam logic [4:0] CH_DAC   = 5'h1D;
  localparam logic [4:0] CH_FREF1 = 5'h1E;
  localparam logic [4:0] CH_FREF2 = 5'h1F;

  // Positive reference codes
  localparam logic [2:0] REF_SUPPLY = 3'h0;
  localparam logic [2:0] REF_PIN    = 3'h1;
  localparam logic [2:0] REF_FIX2   = 3'h2;
  localparam logic [2:0] REF_FIX4   = 3'h3;
  localparam logic [2:0] REF_GROUND = 3'h4;

  // Conversion clock code low bits for the internal RC source
  localparam logic [1:0] CKS_FRC = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b11
  } adcc_state_e;
endpackage

// file: verilog/adcc_clkdiv.sv
// Half bit period enable generator for the converter.
// Assumes the select code is held stable while run_in is high.
`timescale 1ns/1ps
module adcc_clkdiv
  import adcc_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       run_in,
  input  wire logic       restart_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] limit;

  // Divisor decode: system divisors or RC rate
  always_comb begin
    if (sel_in[1:0] == CKS_FRC) begin
      limit = 6'(FRC_HALF_CYC - 1);
    end else begin
      limit = 6'((7'h01 << {sel_in[1:0], sel_in[2]}) - 7'h01);
    end
    tick_out = run_in && (cnt_reg == limit);
    if (restart_in || !run_in || tick_out) begin
      cnt_next = 6'h00;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  // Count register
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// file: verif/adcc_core_model.sv
// Behavioural analog core: sample-hold and comparator behind the converter control.
// Assumes the sequencer raises sample_in while tracking and drives trial words afterwards.
`timescale 1ns/1ps
module adcc_core_model (
  input  wire logic       mclk_in,
  input  wire logic [4:0] channel_in,
  input  wire logic       connect_in,
  input  wire logic       sample_in,
  input  wire logic [9:0] trial_in,
  input  wire logic [9:0] level_in [32],
  output logic            comp_out
);
  logic [9:0] held = 10'h000;
  // Track the routed channel while sampling, hold it during bit trials
  always @(posedge mclk_in) begin
    if (sample_in && connect_in) begin
      held <= level_in[channel_in];
    end
  end
  // Comparator: trial bit kept when the held input reaches the trial word
  assign comp_out = (held >= trial_in);
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the behavioural analog core model on the comparator side.
`timescale 1ns/1ps
module tb_top;
  import adcc_pkg::*;
  logic        mclk_in, reset_n_in, psel_in, penable_in, pwrite_in, sleep_in, comp_in, err;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd, rnd;
  logic        pready_out, pslverr_out, mux_connect_out, ref_valid_out, sample_out, irq_out;
  logic [4:0]  sh_channel_out, ch;
  logic [2:0]  ref_select_out, rf;
  logic [9:0]  trial_out;
  logic [9:0]  lv [32];
  logic [15:0] ex;
  logic        jf;
  int          n_mismatch, total_checks, seed, el;
  int          cyc = 0;
  adcc_top #(.SMALL_VARIANT(1'b1), .LOW_VOLTAGE(1'b1)) adcc_top_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .comp_in(comp_in),
    .sleep_in(sleep_in), .sh_channel_out(sh_channel_out), .mux_connect_out(mux_connect_out),
    .ref_select_out(ref_select_out), .ref_valid_out(ref_valid_out), .sample_out(sample_out),
    .trial_out(trial_out), .irq_out(irq_out));
  adcc_core_model adcc_core_model_i (.mclk_in(mclk_in), .channel_in(sh_channel_out),
    .connect_in(mux_connect_out), .sample_in(sample_out), .trial_in(trial_out), .level_in(lv),
    .comp_out(comp_in));
  // Clock and free-running cycle count
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) cyc <= cyc + 1;
  // Verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_rng(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // One APB transfer: setup, access held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      end_sim;
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task wait_irq;
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 2000) begin
      @(negedge mclk_in);
      n++;
    end
    if (n >= 2000) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  // Channel legality of the smaller variant
  function automatic logic chan_legal(input logic [4:0] c);
    return (c <= 5'h04) || ((c >= 5'h08) && (c <= 5'h13)) || (c >= CH_TEMP);
  endfunction
  // Configure, enable, wait acquisition, then set go
  task start(input logic [4:0] c, input logic [2:0] k, input logic [2:0] r, input logic j);
    apb(1'b1, OFS_CTRL_SECOND, {24'h0, j, k, 1'b0, r});
    apb(1'b1, OFS_CTRL_FIRST, {25'h0, c, 2'b01});
    repeat (4) @(posedge mclk_in);
    chk("sh_channel", 32'(c), 32'(sh_channel_out));
    chk("mux_connect", 32'(chan_legal(c)), 32'(mux_connect_out));
    apb(1'b1, OFS_CTRL_FIRST, {25'h0, c, 2'b11});
  endtask
  function automatic int half(input logic [2:0] k);
    if (k[1:0] == CKS_FRC) return FRC_HALF_CYC;
    return 1 << (2 * k[1:0] + k[2]);
  endfunction
  initial begin
    seed = 32'hff02; n_mismatch = 0; total_checks = 0; reset_n_in = 1'b0; sleep_in = 1'b0;
    psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0; paddr_in = 8'h00; pwdata_in = 32'h0;
    foreach (lv[i]) lv[i] = 10'h000;
    repeat (8) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    // Reset values, unmapped and unaligned addresses
    for (int a = 0; a < 8; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk("reset_read", 32'h0, rd);
      chk("decode_err", 32'(a == 7), 32'(err));
    end
    apb(1'b0, 8'h02, 32'h0);
    chk("unaligned_err", 32'h1, 32'(err));
    // Every reference code, legal and illegal
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, OFS_CTRL_SECOND, 32'(r));
      repeat (2) @(negedge mclk_in);
      chk("ref_valid", 32'((r <= 4) && (r != 3)), 32'(ref_valid_out));
      if (r <= 4) chk("ref_select", 32'(r), 32'(ref_select_out));
    end
    // Enable and go in one write: no conversion
    apb(1'b1, OFS_IRQ_ENABLE, 32'h1);
    apb(1'b1, OFS_CTRL_FIRST, {25'h0, 5'h03, 2'b11});
    repeat (40) @(posedge mclk_in);
    rdc("status_no_start", OFS_IRQ_STATUS, 32'h0);
    rdc("go_ignored", OFS_CTRL_FIRST, {25'h0, 5'h03, 2'b01});
    // Random conversions over every clock code, late writes in flight
    for (int i = 0; i < 16; i++) begin
      rnd = $random(seed);
      ch = (i == 0) ? CH_FREF2 : rnd[4:0];
      if (!chan_legal(ch)) ch = ch | CH_TEMP;
      lv[ch] = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : rnd[17:8];
      jf = rnd[20];
      rf = 3'(rnd[31:24] % 5);
      start(ch, 3'(i), rf, jf);
      el = cyc;
      apb(1'b1, OFS_CTRL_FIRST, {25'h0, ~ch, 2'b11});
      apb(1'b1, OFS_CTRL_SECOND, {24'h0, ~jf, 3'(i), 1'b0, (rf == REF_GROUND) ? REF_SUPPLY : REF_GROUND});
      @(negedge mclk_in);
      chk("held_channel", 32'(ch), 32'(sh_channel_out));
      chk("held_ref", 32'(rf), 32'(ref_select_out));
      wait_irq;
      chk_rng("conv_cycles", 23 * half(3'(i)), 24 * half(3'(i)) + 4, cyc - el);
      ex = jf ? {6'h00, lv[ch]} : {lv[ch], 6'h00};
      rdc("result_high", OFS_RES_HIGH, {24'h0, ex[15:8]});
      rdc("result_low", OFS_RES_LOW, {24'h0, ex[7:0]});
      rdc("status_set", OFS_IRQ_STATUS, 32'h1);
      rdc("go_cleared", OFS_CTRL_FIRST, {25'h0, ~ch, 2'b01});
      apb(1'b1, OFS_IRQ_CLEAR, 32'h1);
      repeat (2) @(negedge mclk_in);
      chk("irq_cleared", 32'h0, 32'(irq_out));
    end
    // Illegal channel on the smaller variant stays disconnected
    apb(1'b1, OFS_CTRL_FIRST, {25'h0, 5'h06, 2'b01});
    repeat (2) @(negedge mclk_in);
    chk("mux_illegal", 32'h0, 32'(mux_connect_out));
    // Masked completion, then unmask and clear
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
    start(5'h07, 3'h0, REF_SUPPLY, 1'b1);
    repeat (40) @(posedge mclk_in);
    chk("irq_masked", 32'h0, 32'(irq_out));
    rdc("status_masked", OFS_IRQ_STATUS, 32'h1);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h1);
    repeat (2) @(negedge mclk_in);
    chk("irq_unmasked", 32'h1, 32'(irq_out));
    apb(1'b1, OFS_IRQ_CLEAR, 32'h1);
    rdc("status_clear", OFS_IRQ_STATUS, 32'h0);
    // Abort by clearing go mid-conversion: no flag
    start(5'h05, 3'h0, REF_SUPPLY, 1'b0);
    repeat (8) @(posedge mclk_in);
    apb(1'b1, OFS_CTRL_FIRST, {25'h0, 5'h05, 2'b01});
    repeat (40) @(posedge mclk_in);
    rdc("status_abort", OFS_IRQ_STATUS, 32'h0);
    // Sleep: RC conversion completes and wakes, system clock code is blocked
    sleep_in <= 1'b1;
    lv[9] = 10'h155;
    start(5'h09, 3'h3, REF_PIN, 1'b1);
    wait_irq;
    rdc("sleep_result", OFS_RES_LOW, 32'h55);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h1);
    start(5'h09, 3'h0, REF_PIN, 1'b1);
    repeat (40) @(posedge mclk_in);
    rdc("sleep_blocked", OFS_IRQ_STATUS, 32'h0);
    sleep_in <= 1'b0;
    end_sim;
  end
endmodule
